// File: speed_framer_consts.svh
`ifndef SPEED_FRAMER_CONSTS_SVH
`define SPEED_FRAMER_CONSTS_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_PERIOD      8'h04
`define OFS_LIVE        8'h08
`define OFS_PEAK        8'h0c
`define OFS_HIT         8'h10
`define OFS_LOCKED      8'h14
`define OFS_TARGET      8'h18
`define OFS_STATUS      8'h1c

// Control register fields
`define CTRL_ENABLE     0
`define CTRL_MULTIDROP  1
`define CTRL_FMT_LO     2
`define CTRL_TENTHS     4
`define CTRL_SEL_LO     5
`define CTRL_LEAD_SPACE 7
`define CTRL_TERM_LF    8
`define CTRL_SPLIT      9
`define CTRL_TRANSMIT   10
`define CTRL_PEAK_EN    11
`define CTRL_W          12
`define CTRL_RST        12'h020

// Target register fields
`define TGT_LOCKED      0
`define TGT_OUTBOUND    1

// Message bytes
`define ASC_CR          8'h0d
`define ASC_LF          8'h0a
`define ASC_DOT         8'h2e
`define ASC_SPACE       8'h20
`define ASC_ZERO        8'h30
`define ASC_NINE        8'h39
`define MULTI_TYPE      8'h81
`define CFG_FIXED       8'h42
`define CFG_LOCK_BIT    5
`define CFG_DIR_BIT     4
`define CFG_SPLIT_BIT   3
`define CFG_XMIT_BIT    0
`define STAT_FIXED      8'h40
`define STAT_PEAK_BIT   2

// Timing
`define CLK_HZ          25000000
`define MSG_PERIOD_MS   100
`define MSG_PERIOD_CYC  ((`CLK_HZ / 1000) * `MSG_PERIOD_MS)

`endif

// File: speed_framer_pkg.sv
package speed_framer_pkg;

    typedef enum logic [1:0] {
        short_single_speed_format,
        four_digit_single_speed_format,
        multi_speed_format
    } format_type;

    typedef enum logic [1:0] {
        sel_live,
        sel_peak,
        sel_hit
    } speed_sel_type;

    typedef enum logic {
        tx_idle,
        tx_send
    } tx_state_type;

    typedef logic [13:0] speed_type;

endpackage : speed_framer_pkg

// File: speed_framer.sv
`timescale 1ns/1ps
`include "speed_framer_consts.svh"

module speed_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0]   count;
    } fifo_state_type;

    fifo_state_type   cur;
    fifo_state_type   next_cur;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_fifo
        $error("fifo depth must be a power of two of at least 2");
    end

    assign in_ready  = cur.count != (PW+1)'(DEPTH);
    assign out_valid = cur.count != '0;
    assign out_data  = mem[cur.rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_cur = cur;
        if (push) begin
            next_cur.wr_ptr = cur.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_cur.rd_ptr = cur.rd_ptr + 1'b1;
        end
        next_cur.count = cur.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[cur.wr_ptr] <= in_data;
        end
    end
endmodule : speed_byte_fifo

module speed_framer #(
    parameter int PERIOD_CYCLES = `MSG_PERIOD_CYC,
    parameter int FIFO_DEPTH    = 8
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Poll from the command decoder, same clock
    input  wire logic        speed_request_poll,
    // Byte stream to the serial transmitter
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready
);
    typedef struct packed {
        logic [`CTRL_W-1:0]          ctrl;
        logic [31:0]                 period;
        speed_framer_pkg::speed_type live;
        speed_framer_pkg::speed_type peak;
        speed_framer_pkg::speed_type hit;
        speed_framer_pkg::speed_type lock;
        logic [1:0]                  target;
        logic [31:0]                 rdata;
        speed_framer_pkg::tx_state_type st;
        logic [4:0]                  idx;
        logic [31:0]                 timer;
        logic                        poll_pend;
        logic [15:0]                 msg_count;
        speed_framer_pkg::format_type s_fmt;
        logic                        s_tenths;
        logic                        s_term;
        logic                        s_lead;
        speed_framer_pkg::speed_type s_sel;
        speed_framer_pkg::speed_type s_lock;
        speed_framer_pkg::speed_type s_peak;
        speed_framer_pkg::speed_type s_live;
        logic [7:0]                  s_cfg;
        logic [7:0]                  s_stat;
    } state_type;

    state_type  cur;
    state_type  next_cur;
    logic       fifo_in_ready;
    logic       push;
    logic [8:0] pbyte;
    logic       msg_start;

    if (PERIOD_CYCLES < 1) begin : g_bad_period
        $error("message period must be at least one cycle");
    end

    function automatic logic [16:0] pow10(input logic [2:0] p);
        unique case (p)
            3'd0:    pow10 = 17'd1;
            3'd1:    pow10 = 17'd10;
            3'd2:    pow10 = 17'd100;
            3'd3:    pow10 = 17'd1000;
            3'd4:    pow10 = 17'd10000;
            default: pow10 = 17'd100000;
        endcase
    endfunction : pow10

    // Saturates at all nines when the speed has more digits than the field
    function automatic speed_framer_pkg::speed_type clamp(
        input speed_framer_pkg::speed_type v, input logic [2:0] n);
        logic [16:0] mx;
        mx = pow10(n) - 17'd1;
        clamp = ({3'b0, v} > mx) ? speed_framer_pkg::speed_type'(mx) : v;
    endfunction : clamp

    function automatic logic [7:0] digit(input speed_framer_pkg::speed_type v,
        input logic [2:0] p, input logic [2:0] mp, input logic lead);
        logic [16:0] q;
        logic [3:0]  d;
        q = {3'b0, v} / pow10(p);
        d = 4'(q % 17'd10);
        if (lead && p > mp && q == 17'd0) begin
            digit = `ASC_SPACE;
        end else begin
            digit = `ASC_ZERO + {4'h0, d};
        end
    endfunction : digit

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
        input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
        merge = old;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `OFS_STATUS);
    endfunction : mapped

    // Byte at the current index of the message snapshot, with its last-byte flag on top
    function automatic logic [8:0] msg_byte(input state_type s);
        logic [2:0] intdig;
        logic [2:0] nd;
        logic [2:0] mp;
        logic [4:0] cr_i;
        logic [7:0] b;
        logic       last;
        intdig = (s.s_fmt == speed_framer_pkg::four_digit_single_speed_format) ? 3'd4 : 3'd3;
        nd     = intdig + {2'b0, s.s_tenths};
        mp     = {2'b0, s.s_tenths};
        cr_i   = {2'b0, intdig} + (s.s_tenths ? 5'd2 : 5'd0);
        b      = `ASC_SPACE;
        last   = 1'b0;
        if (s.s_fmt == speed_framer_pkg::multi_speed_format) begin
            if (s.idx == 5'd0) begin
                b = `MULTI_TYPE;
            end else if (s.idx == 5'd1) begin
                b = s.s_cfg;
            end else if (s.idx == 5'd2) begin
                b = s.s_stat;
            end else if (s.idx <= 5'd5) begin
                b = `ASC_ZERO;
            end else if (s.idx <= 5'd8) begin
                b = digit(s.s_lock, 3'(5'd8 - s.idx), 3'd0, s.s_lead);
            end else if (s.idx <= 5'd11) begin
                b = digit(s.s_peak, 3'(5'd11 - s.idx), 3'd0, s.s_lead);
            end else if (s.idx <= 5'd14) begin
                b = digit(s.s_live, 3'(5'd14 - s.idx), 3'd0, s.s_lead);
            end else begin
                b    = `ASC_CR;
                last = 1'b1;
            end
        end else begin
            if (s.idx < {2'b0, intdig}) begin
                b = digit(s.s_sel, 3'({2'b0, nd} - 5'd1 - s.idx), mp, s.s_lead);
            end else if (s.s_tenths && s.idx == {2'b0, intdig}) begin
                b = `ASC_DOT;
            end else if (s.s_tenths && s.idx == {2'b0, intdig} + 5'd1) begin
                b = digit(s.s_sel, 3'd0, mp, s.s_lead);
            end else if (s.idx == cr_i) begin
                b    = `ASC_CR;
                last = ~s.s_term;
            end else begin
                b    = `ASC_LF;
                last = 1'b1;
            end
        end
        msg_byte = {last, b};
    endfunction : msg_byte

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);
    assign prdata  = cur.rdata;
    assign push    = (cur.st == speed_framer_pkg::tx_send) & fifo_in_ready;
    assign pbyte   = msg_byte(cur);

    always_comb begin
        logic [2:0] nd;
        speed_framer_pkg::speed_type sel;
        nd        = 3'd0;
        sel       = '0;
        next_cur  = cur;
        msg_start = 1'b0;
        if (psel && penable && pwrite) begin
            unique case (paddr)
                `OFS_CTRL:   next_cur.ctrl   = `CTRL_W'(merge(32'(cur.ctrl), pwdata, pstrb));
                `OFS_PERIOD: next_cur.period = merge(cur.period, pwdata, pstrb);
                `OFS_LIVE:   next_cur.live   = 14'(merge(32'(cur.live), pwdata, pstrb));
                `OFS_PEAK:   next_cur.peak   = 14'(merge(32'(cur.peak), pwdata, pstrb));
                `OFS_HIT:    next_cur.hit    = 14'(merge(32'(cur.hit), pwdata, pstrb));
                `OFS_LOCKED: next_cur.lock   = 14'(merge(32'(cur.lock), pwdata, pstrb));
                `OFS_TARGET: next_cur.target = 2'(merge(32'(cur.target), pwdata, pstrb));
                default:     next_cur.ctrl   = cur.ctrl;
            endcase
        end
        if (psel && !penable) begin
            unique case (paddr)
                `OFS_CTRL:   next_cur.rdata = 32'(cur.ctrl);
                `OFS_PERIOD: next_cur.rdata = cur.period;
                `OFS_LIVE:   next_cur.rdata = 32'(cur.live);
                `OFS_PEAK:   next_cur.rdata = 32'(cur.peak);
                `OFS_HIT:    next_cur.rdata = 32'(cur.hit);
                `OFS_LOCKED: next_cur.rdata = 32'(cur.lock);
                `OFS_TARGET: next_cur.rdata = 32'(cur.target);
                `OFS_STATUS: next_cur.rdata = {cur.msg_count, 14'h0, cur.poll_pend,
                                               cur.st == speed_framer_pkg::tx_send};
                default:     next_cur.rdata = 32'h0000_0000;
            endcase
        end
        // Streaming timer runs only in point-to-point mode
        if (!cur.ctrl[`CTRL_ENABLE] || cur.ctrl[`CTRL_MULTIDROP]) begin
            next_cur.timer = 32'h0000_0000;
        end else if (cur.timer != 32'h0000_0000) begin
            next_cur.timer = cur.timer - 32'd1;
        end
        if (cur.st == speed_framer_pkg::tx_idle && cur.ctrl[`CTRL_ENABLE]) begin
            msg_start = cur.ctrl[`CTRL_MULTIDROP] ? cur.poll_pend
                                                  : (cur.timer == 32'h0000_0000);
        end
        if (msg_start) begin
            next_cur.st       = speed_framer_pkg::tx_send;
            next_cur.idx      = 5'd0;
            next_cur.timer    = cur.ctrl[`CTRL_MULTIDROP] ? 32'h0000_0000
                                : (cur.period - 32'd1);
            next_cur.s_fmt    = speed_framer_pkg::format_type'(cur.ctrl[`CTRL_FMT_LO +: 2]);
            if (cur.ctrl[`CTRL_FMT_LO +: 2] == 2'b11) begin
                next_cur.s_fmt = speed_framer_pkg::short_single_speed_format;
            end
            next_cur.s_tenths = cur.ctrl[`CTRL_TENTHS];
            next_cur.s_term   = cur.ctrl[`CTRL_TERM_LF];
            next_cur.s_lead   = cur.ctrl[`CTRL_LEAD_SPACE];
            nd  = (next_cur.s_fmt == speed_framer_pkg::four_digit_single_speed_format ? 3'd4 : 3'd3)
                  + {2'b0, cur.ctrl[`CTRL_TENTHS]};
            unique case (cur.ctrl[`CTRL_SEL_LO +: 2])
                2'd0:    sel = cur.live;
                2'd2:    sel = cur.hit;
                default: sel = cur.peak;
            endcase
            next_cur.s_sel    = clamp(sel, nd);
            next_cur.s_lock   = clamp(cur.lock, 3'd3);
            next_cur.s_peak   = clamp(cur.peak, 3'd3);
            next_cur.s_live   = clamp(cur.live, 3'd3);
            next_cur.s_cfg    = `CFG_FIXED;
            next_cur.s_cfg[`CFG_LOCK_BIT]  = cur.target[`TGT_LOCKED];
            next_cur.s_cfg[`CFG_DIR_BIT]   = cur.target[`TGT_OUTBOUND];
            next_cur.s_cfg[`CFG_SPLIT_BIT] = cur.ctrl[`CTRL_SPLIT];
            next_cur.s_cfg[`CFG_XMIT_BIT]  = cur.ctrl[`CTRL_TRANSMIT];
            next_cur.s_stat   = `STAT_FIXED;
            next_cur.s_stat[`STAT_PEAK_BIT] = cur.ctrl[`CTRL_PEAK_EN];
        end
        // A poll arriving as the pending one is taken stays pending
        next_cur.poll_pend = (cur.poll_pend & ~msg_start)
                             | (speed_request_poll & cur.ctrl[`CTRL_MULTIDROP]);
        if (push) begin
            if (pbyte[8]) begin
                next_cur.st        = speed_framer_pkg::tx_idle;
                next_cur.msg_count = cur.msg_count + 16'd1;
            end else begin
                next_cur.idx = cur.idx + 5'd1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur        <= '0;
            cur.ctrl   <= `CTRL_RST;
            cur.period <= 32'(PERIOD_CYCLES);
        end else begin
            cur <= next_cur;
        end
    end

    speed_byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (cur.st == speed_framer_pkg::tx_send),
        .in_ready  (fifo_in_ready),
        .in_data   (pbyte[7:0]),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_poll_idle;
        speed_request_poll && cur.ctrl[`CTRL_MULTIDROP] && cur.ctrl[`CTRL_ENABLE]
            && cur.st == speed_framer_pkg::tx_idle && !cur.poll_pend;
    endsequence

    sequence s_msg_taken;
        msg_start ##1 (cur.st == speed_framer_pkg::tx_send && cur.idx == 5'd0);
    endsequence

    a_stream_period: assert property (msg_start && !cur.ctrl[`CTRL_MULTIDROP]
        |=> cur.timer == $past(cur.period) - 32'd1)
        else $error("stream timer not reloaded with the message period");
    a_poll_answer: assert property (s_poll_idle |=> s_msg_taken)
        else $error("poll not answered by a message start");
    a_poll_needed: assert property (msg_start && cur.ctrl[`CTRL_MULTIDROP] |-> cur.poll_pend)
        else $error("multidrop message started without a poll");
    a_short_cr: assert property (push && cur.s_fmt == speed_framer_pkg::short_single_speed_format
        && !cur.s_tenths && cur.idx == 5'd3 |-> pbyte[7:0] == `ASC_CR)
        else $error("short ones message byte four is not carriage return");
    a_tenths_point: assert property (push && cur.s_fmt != speed_framer_pkg::multi_speed_format
        && cur.s_tenths && cur.idx == (cur.s_fmt == speed_framer_pkg::short_single_speed_format
        ? 5'd3 : 5'd4) |-> pbyte[7:0] == `ASC_DOT)
        else $error("decimal point missing at tenths resolution");
    a_digit_range: assert property (push && ((cur.s_fmt != speed_framer_pkg::multi_speed_format
        && cur.idx < 5'd3) || (cur.s_fmt == speed_framer_pkg::multi_speed_format
        && cur.idx >= 5'd6 && cur.idx <= 5'd14))
        |-> (pbyte[7:0] >= `ASC_ZERO && pbyte[7:0] <= `ASC_NINE) || pbyte[7:0] == `ASC_SPACE)
        else $error("digit byte is neither numeral nor space");
    a_four_length: assert property (push && pbyte[8]
        && cur.s_fmt == speed_framer_pkg::four_digit_single_speed_format && !cur.s_term
        |-> cur.idx == (cur.s_tenths ? 5'd6 : 5'd4))
        else $error("four-digit message has the wrong length");
    a_multi_type: assert property (push && cur.s_fmt == speed_framer_pkg::multi_speed_format
        && cur.idx == 5'd0 |-> pbyte[7:0] == `MULTI_TYPE)
        else $error("multi-speed message type byte wrong");
    a_multi_end: assert property (push && cur.s_fmt == speed_framer_pkg::multi_speed_format
        && pbyte[8] |-> cur.idx == 5'd15 && pbyte[7:0] == `ASC_CR)
        else $error("multi-speed message does not end in byte sixteen");
    a_cfg_fixed: assert property (push && cur.s_fmt == speed_framer_pkg::multi_speed_format
        && cur.idx == 5'd1 |-> pbyte[7:6] == 2'b01 && pbyte[2:1] == 2'b01)
        else $error("configuration byte fixed bits wrong");
    a_cfg_lock: assert property (msg_start && cur.ctrl[`CTRL_FMT_LO +: 2] == 2'b10
        |=> cur.s_cfg[`CFG_LOCK_BIT] == $past(cur.target[`TGT_LOCKED])
        && cur.s_cfg[`CFG_DIR_BIT] == $past(cur.target[`TGT_OUTBOUND]))
        else $error("lock or direction bit not taken from the target register");
    a_stat_fixed: assert property (push && cur.s_fmt == speed_framer_pkg::multi_speed_format
        && cur.idx == 5'd2 |-> pbyte[7:3] == 5'b01000 && pbyte[1:0] == 2'b00)
        else $error("status byte fixed bits wrong");
    a_byte_order: assert property (push && !pbyte[8]
        |=> cur.st == speed_framer_pkg::tx_send && cur.idx == $past(cur.idx) + 5'd1)
        else $error("message bytes not sent in ascending order");
endmodule : speed_framer

// File: speed_sink.sv
`timescale 1ns/1ps
module speed_sink (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Byte stream from the framer
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // Pacing set by the bench
    input  wire logic       stall,
    input  wire logic       slow
);
    logic [7:0] q[$];
    int         st[$];
    int         cyc;

    // Takes at most one byte a cycle, fast enough that a message clears before the next
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            cyc      <= 0;
        end else begin
            cyc      <= cyc + 1;
            tx_ready <= !stall && !(slow && tx_ready);
            if (tx_valid && tx_ready) begin
                q.push_back(tx_data);
                if (tx_data == 8'h0d)
                    st.push_back(cyc);
            end
        end
    end
endmodule : speed_sink

// File: tb.sv
`timescale 1ns/1ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, poll, stall, slow;
    logic        pready, pslverr, e, tx_valid, tx_ready;
    logic [7:0]  paddr, tx_data;
    logic [31:0] pwdata, prdata, r;
    int          bad_count, tests_run, cyc;
    string       exp [6];
    logic [31:0] ctl [6];
    string       s;

    speed_framer #(.PERIOD_CYCLES(64)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .speed_request_poll(poll),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    speed_sink sink (.pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .stall(stall), .slow(slow));

    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk32(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value at %0t: word %h expected %h", $time, g, x);
        end
    endtask : chk32

    task automatic chk8(input logic [7:0] g, input logic [7:0] x);
        tests_run++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value at %0t: byte %h expected %h", $time, g, x);
        end
    endtask : chk8

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1;
        penable <= 0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 0;
        penable <= 0;
    endtask : apb

    task automatic poll_once();
        @(posedge pclk);
        poll <= 1;
        @(posedge pclk);
        poll <= 0;
    endtask : poll_once

    task automatic expect_msg(input string m);
        int n;
        n = 0;
        while (sink.q.size() < m.len() && n < 500) begin
            @(posedge pclk);
            n++;
        end
        repeat (30) @(posedge pclk);
        chk32(sink.q.size(), m.len());
        for (int i = 0; i < m.len(); i++)
            chk8(sink.q[i], m[i]);
        sink.q.delete();
    endtask : expect_msg

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        {presetn, psel, penable, pwrite, poll, stall, slow} = 0;
        paddr = 0;
        pwdata = 0;
        ctl[0] = 32'h023;
        exp[0] = "042\x0d";
        ctl[1] = 32'h083;
        exp[1] = "  7\x0d";
        ctl[2] = 32'h053;
        exp[2] = "030.5\x0d";
        ctl[3] = 32'h127;
        exp[3] = "0042\x0d\x0a";
        ctl[4] = 32'h017;
        exp[4] = "0000.7\x0d";
        ctl[5] = 32'he0b;
        exp[5] = "\x81{D000123042007\x0d";
        s = "042\x0d";
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(8'h00, 0, 0);
        chk32(r, 32'h020);
        apb(8'h04, 0, 0);
        chk32(r, 64);
        apb(8'h20, 0, 0);
        chk32(r, 32'h0);
        chk32({31'h0, e}, 32'h1);
        $display("test reset done");
        apb(8'h08, 1, 7);
        apb(8'h0c, 1, 42);
        apb(8'h10, 1, 305);
        apb(8'h14, 1, 123);
        apb(8'h18, 1, 3);
        for (int i = 0; i < 6; i++) begin
            apb(8'h00, 1, ctl[i]);
            poll_once();
            expect_msg(exp[i]);
        end
        $display("test formats done");
        apb(8'h08, 1, 1234);
        apb(8'h00, 1, 32'h01b);
        stall <= 1;
        slow  <= 1;
        poll_once();
        repeat (40) @(posedge pclk);
        chk32(sink.q.size(), 0);
        apb(8'h1c, 0, 0);
        chk32({31'h0, r[0]}, 32'h1);
        stall <= 0;
        expect_msg("\x81r@000123042999\x0d");
        slow <= 0;
        $display("test stall done");
        sink.st.delete();
        apb(8'h00, 1, 32'h021);
        repeat (230) @(posedge pclk);
        apb(8'h00, 1, 0);
        repeat (30) @(posedge pclk);
        chk32(sink.q.size(), 16);
        chk32(sink.st.size(), 4);
        for (int i = 1; i < 4; i++)
            chk32(sink.st[i] - sink.st[i-1], 64);
        for (int i = 0; i < 16; i++)
            chk8(sink.q[i], s[i%4]);
        $display("test stream done");
        tally_and_finish();
    end
endmodule : tb
